// ===== hdl/pfccfg_defines.vh
// Register offsets, reset values and timing counts for the PFC config bank.
`ifndef PFCCFG_DEFINES_VH
`define PFCCFG_DEFINES_VH
`define PFCCFG_ADDR_VOUT_HL_LO 8'h01
`define PFCCFG_ADDR_VOUT_HL_HI 8'h02
`define PFCCFG_ADDR_VOUT_LL_LO 8'h03
`define PFCCFG_ADDR_VOUT_LL_HI 8'h04
`define PFCCFG_ADDR_LINE_THR 8'h05
`define PFCCFG_ADDR_LOAD1_LO 8'h06
`define PFCCFG_ADDR_LOAD1_HI 8'h07
`define PFCCFG_ADDR_LOAD2_LO 8'h08
`define PFCCFG_ADDR_LOAD2_HI 8'h09
`define PFCCFG_ADDR_BURST 8'h0a
`define PFCCFG_ADDR_HYST_LO 8'h0c
`define PFCCFG_ADDR_HYST_HI 8'h0d
`define PFCCFG_ADDR_HL1_LO 8'h0e
`define PFCCFG_ADDR_HL2_LO 8'h0f
`define PFCCFG_ADDR_HL_UPPER 8'h11
`define PFCCFG_ADDR_LL1_LO 8'h12
`define PFCCFG_ADDR_PROT_CTRL 8'h30
`define PFCCFG_ADDR_PROT_STAT 8'h31
`define PFCCFG_RST_VOUT_HL 10'h31e
`define PFCCFG_RST_VOUT_LL 10'h31e
`define PFCCFG_RST_LINE_THR 8'h71
`define PFCCFG_RST_LOAD1 14'h03fc
`define PFCCFG_RST_LOAD2 14'h0332
`define PFCCFG_RST_BURST 5'h17
`define PFCCFG_RST_HYST 14'h00f5
`define PFCCFG_RST_HL1_LO 8'h1e
`define PFCCFG_RST_HL2_LO 8'h1e
`define PFCCFG_RST_HL_UPPER 4'hf
`define PFCCFG_RST_LL1_LO 8'h1e
`define PFCCFG_RST_PROT_CTRL 1'b0
`define PFCCFG_BIT_PFC_LATCH 0
`define PFCCFG_TIMER_US 1000
`define PFCCFG_CLK_MHZ 40
`endif

// ===== hdl/pfccfg_timer.v
// One-shot protection restart timer counting clock cycles.
`timescale 1ns/10ps
module pfccfg_timer #(
    parameter CYCLES = 40000,
    parameter W = 24
) (
    // Clock and reset.
    input wire clk,
    input wire rst,
    // Control.
    input wire start,
    // Status.
    output wire busy,
    output reg done
);
    reg [W-1:0] cnt_r;
    assign busy = (cnt_r != {W{1'b0}});
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= {W{1'b0}};
            done <= 1'b0;
        end else begin
            done <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
            if (start) begin
                cnt_r <= CYCLES[W-1:0];
            end else if (busy) begin
                cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

// ===== hdl/pfccfg_regfile.v
// Byte-wide configuration register storage with documented defaults.
`timescale 1ns/10ps
`include "pfccfg_defines.vh"
module pfccfg_regfile (
    // Clock and reset.
    input wire clk,
    input wire rst,
    // Byte write port.
    input wire wr_en,
    input wire [7:0] wr_addr,
    input wire [7:0] wr_data,
    // Byte read port.
    input wire [7:0] rd_addr,
    output reg [7:0] rd_data,
    output reg rd_hit,
    // Stored fields.
    output reg [9:0] vout_target_high_line,
    output reg [9:0] vout_target_low_line,
    output reg [7:0] line_range_threshold,
    output reg [13:0] auto_step_load_level_one,
    output reg [13:0] auto_step_load_level_two,
    output reg [4:0] burst_exit_threshold,
    output reg [13:0] auto_step_load_hysteresis,
    output reg [7:0] high_line_level_one_low_byte,
    output reg [7:0] high_line_level_two_low_byte,
    output reg [3:0] high_line_levels_upper_bits,
    output reg [7:0] low_line_level_one_low_byte
);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            vout_target_high_line <= `PFCCFG_RST_VOUT_HL;
            vout_target_low_line <= `PFCCFG_RST_VOUT_LL;
            line_range_threshold <= `PFCCFG_RST_LINE_THR;
            auto_step_load_level_one <= `PFCCFG_RST_LOAD1;
            auto_step_load_level_two <= `PFCCFG_RST_LOAD2;
            burst_exit_threshold <= `PFCCFG_RST_BURST;
            auto_step_load_hysteresis <= `PFCCFG_RST_HYST;
            high_line_level_one_low_byte <= `PFCCFG_RST_HL1_LO;
            high_line_level_two_low_byte <= `PFCCFG_RST_HL2_LO;
            high_line_levels_upper_bits <= `PFCCFG_RST_HL_UPPER;
            low_line_level_one_low_byte <= `PFCCFG_RST_LL1_LO;
        end else if (wr_en) begin
            case (wr_addr)
                `PFCCFG_ADDR_VOUT_HL_LO:
                    vout_target_high_line[7:0] <= wr_data;
                `PFCCFG_ADDR_VOUT_HL_HI:
                    vout_target_high_line[9:8] <= wr_data[1:0];
                `PFCCFG_ADDR_VOUT_LL_LO:
                    vout_target_low_line[7:0] <= wr_data;
                `PFCCFG_ADDR_VOUT_LL_HI:
                    vout_target_low_line[9:8] <= wr_data[1:0];
                `PFCCFG_ADDR_LINE_THR:
                    line_range_threshold <= wr_data;
                `PFCCFG_ADDR_LOAD1_LO:
                    auto_step_load_level_one[7:0] <= wr_data;
                `PFCCFG_ADDR_LOAD1_HI:
                    auto_step_load_level_one[13:8] <= wr_data[5:0];
                `PFCCFG_ADDR_LOAD2_LO:
                    auto_step_load_level_two[7:0] <= wr_data;
                `PFCCFG_ADDR_LOAD2_HI:
                    auto_step_load_level_two[13:8] <= wr_data[5:0];
                `PFCCFG_ADDR_BURST:
                    burst_exit_threshold <= wr_data[4:0];
                `PFCCFG_ADDR_HYST_LO:
                    auto_step_load_hysteresis[7:0] <= wr_data;
                `PFCCFG_ADDR_HYST_HI:
                    auto_step_load_hysteresis[13:8] <= wr_data[5:0];
                `PFCCFG_ADDR_HL1_LO:
                    high_line_level_one_low_byte <= wr_data;
                `PFCCFG_ADDR_HL2_LO:
                    high_line_level_two_low_byte <= wr_data;
                `PFCCFG_ADDR_HL_UPPER:
                    high_line_levels_upper_bits <= wr_data[3:0];
                `PFCCFG_ADDR_LL1_LO:
                    low_line_level_one_low_byte <= wr_data;
                default: begin
                end
            endcase
        end
    end

    always @* begin
        rd_hit = 1'b1;
        case (rd_addr)
            `PFCCFG_ADDR_VOUT_HL_LO: rd_data = vout_target_high_line[7:0];
            `PFCCFG_ADDR_VOUT_HL_HI:
                rd_data = {6'h00, vout_target_high_line[9:8]};
            `PFCCFG_ADDR_VOUT_LL_LO: rd_data = vout_target_low_line[7:0];
            `PFCCFG_ADDR_VOUT_LL_HI:
                rd_data = {6'h00, vout_target_low_line[9:8]};
            `PFCCFG_ADDR_LINE_THR: rd_data = line_range_threshold;
            `PFCCFG_ADDR_LOAD1_LO: rd_data = auto_step_load_level_one[7:0];
            `PFCCFG_ADDR_LOAD1_HI:
                rd_data = {2'h0, auto_step_load_level_one[13:8]};
            `PFCCFG_ADDR_LOAD2_LO: rd_data = auto_step_load_level_two[7:0];
            `PFCCFG_ADDR_LOAD2_HI:
                rd_data = {2'h0, auto_step_load_level_two[13:8]};
            `PFCCFG_ADDR_BURST: rd_data = {3'h0, burst_exit_threshold};
            `PFCCFG_ADDR_HYST_LO: rd_data = auto_step_load_hysteresis[7:0];
            `PFCCFG_ADDR_HYST_HI:
                rd_data = {2'h0, auto_step_load_hysteresis[13:8]};
            `PFCCFG_ADDR_HL1_LO: rd_data = high_line_level_one_low_byte;
            `PFCCFG_ADDR_HL2_LO: rd_data = high_line_level_two_low_byte;
            `PFCCFG_ADDR_HL_UPPER:
                rd_data = {4'h0, high_line_levels_upper_bits};
            `PFCCFG_ADDR_LL1_LO: rd_data = low_line_level_one_low_byte;
            default: begin
                rd_data = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end
endmodule

// ===== hdl/pfccfg_top.v
// Configuration register bank and protection response logic.
`timescale 1ns/10ps
`include "pfccfg_defines.vh"
module pfccfg_top #(
    parameter TIMER_CYCLES = `PFCCFG_TIMER_US * `PFCCFG_CLK_MHZ
) (
    // Clock and reset.
    input wire clk,
    input wire rst,
    // Register access port, byte wide.
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    output reg reg_err,
    // Fault detector inputs, active high levels.
    input wire supply_undervoltage,
    input wire supply_short,
    input wire rail_undervoltage,
    input wire line_brownout,
    input wire correction_current_limit,
    input wire correction_output_undervoltage,
    input wire resonant_brownout,
    input wire half_bridge_overcurrent_regulation,
    input wire half_bridge_overcurrent_shutdown,
    input wire latch_shutdown,
    input wire supply_below_reset,
    // Protection actions.
    output reg system_enable,
    output reg correction_switch_en,
    output reg half_bridge_switch_en,
    output reg startup_current_limit,
    output reg rail_charge_limit,
    // Configuration fields.
    output wire [9:0] vout_target_high_line,
    output wire [9:0] vout_target_low_line,
    output wire [7:0] line_range_threshold,
    output wire [13:0] auto_step_load_level_one,
    output wire [13:0] auto_step_load_level_two,
    output wire [4:0] burst_exit_threshold,
    output wire [13:0] auto_step_load_hysteresis,
    output wire [7:0] high_line_level_one_low_byte,
    output wire [7:0] high_line_level_two_low_byte,
    output wire [3:0] high_line_levels_upper_bits,
    output wire [7:0] low_line_level_one_low_byte
);
    localparam ST_RUN = 3'b001;
    localparam ST_OFF = 3'b010;
    localparam ST_WAIT = 3'b100;

    wire [7:0] rf_rdata;
    wire rf_hit;
    wire tmr_busy;
    wire tmr_done;
    reg tmr_start;
    reg pfc_latch_mode_r;
    reg latched_off_r;
    reg pfc_latched_r;
    reg [2:0] pfc_st_r;
    reg [2:0] pfc_st_nxt;
    reg [2:0] hb_st_r;
    reg [2:0] hb_st_nxt;
    reg sys_fault;
    reg pfc_start;
    reg hb_start;

    pfccfg_regfile u_rf (
        .clk(clk),
        .rst(rst),
        .wr_en(reg_wr),
        .wr_addr(reg_addr),
        .wr_data(reg_wdata),
        .rd_addr(reg_addr),
        .rd_data(rf_rdata),
        .rd_hit(rf_hit),
        .vout_target_high_line(vout_target_high_line),
        .vout_target_low_line(vout_target_low_line),
        .line_range_threshold(line_range_threshold),
        .auto_step_load_level_one(auto_step_load_level_one),
        .auto_step_load_level_two(auto_step_load_level_two),
        .burst_exit_threshold(burst_exit_threshold),
        .auto_step_load_hysteresis(auto_step_load_hysteresis),
        .high_line_level_one_low_byte(high_line_level_one_low_byte),
        .high_line_level_two_low_byte(high_line_level_two_low_byte),
        .high_line_levels_upper_bits(high_line_levels_upper_bits),
        .low_line_level_one_low_byte(low_line_level_one_low_byte)
    );

    // One timer serves both stages; a new trip simply reloads it.
    pfccfg_timer #(
        .CYCLES(TIMER_CYCLES)
    ) u_tmr (
        .clk(clk),
        .rst(rst),
        .start(tmr_start),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // Protection control register and registered read data.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pfc_latch_mode_r <= `PFCCFG_RST_PROT_CTRL;
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
            reg_err <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `PFCCFG_ADDR_PROT_CTRL) begin
                pfc_latch_mode_r <= reg_wdata[`PFCCFG_BIT_PFC_LATCH];
            end
            reg_rvalid <= reg_rd;
            reg_err <= 1'b0;
            if (reg_rd) begin
                if (rf_hit) begin
                    reg_rdata <= rf_rdata;
                end else if (reg_addr == `PFCCFG_ADDR_PROT_CTRL) begin
                    reg_rdata <= {7'h00, pfc_latch_mode_r};
                end else if (reg_addr == `PFCCFG_ADDR_PROT_STAT) begin
                    reg_rdata <= {3'h0, tmr_busy, pfc_latched_r,
                        latched_off_r, system_enable, half_bridge_switch_en};
                end else begin
                    reg_rdata <= 8'h00;
                    reg_err <= 1'b1;
                end
            end
        end
    end

    // Latched shutdown clears only on supply reset.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            latched_off_r <= 1'b0;
            pfc_latched_r <= 1'b0;
        end else begin
            if (latch_shutdown) begin
                latched_off_r <= 1'b1;
            end else if (supply_below_reset) begin
                latched_off_r <= 1'b0;
            end
            if (correction_current_limit && pfc_latch_mode_r) begin
                pfc_latched_r <= 1'b1;
            end else if (supply_below_reset) begin
                pfc_latched_r <= 1'b0;
            end
        end
    end

    always @* begin
        sys_fault = supply_undervoltage | supply_short | rail_undervoltage
            | latched_off_r | latch_shutdown;
        pfc_st_nxt = pfc_st_r;
        pfc_start = 1'b0;
        case (pfc_st_r)
            ST_RUN: begin
                if (correction_current_limit && !pfc_latch_mode_r) begin
                    pfc_st_nxt = ST_WAIT;
                    pfc_start = 1'b1;
                end
            end
            ST_WAIT: begin
                if (tmr_done) begin
                    pfc_st_nxt = ST_RUN;
                end
            end
            ST_OFF: pfc_st_nxt = ST_RUN;
            default: pfc_st_nxt = ST_RUN;
        endcase
        hb_st_nxt = hb_st_r;
        hb_start = 1'b0;
        case (hb_st_r)
            ST_RUN: begin
                if (half_bridge_overcurrent_regulation) begin
                    hb_st_nxt = ST_WAIT;
                    hb_start = 1'b1;
                end else if (half_bridge_overcurrent_shutdown) begin
                    hb_st_nxt = ST_OFF;
                    hb_start = 1'b1;
                end
            end
            ST_OFF, ST_WAIT: begin
                if (tmr_done) begin
                    hb_st_nxt = ST_RUN;
                end
            end
            default: hb_st_nxt = ST_RUN;
        endcase
        tmr_start = pfc_start | hb_start;
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pfc_st_r <= ST_RUN;
            hb_st_r <= ST_RUN;
            system_enable <= 1'b0;
            correction_switch_en <= 1'b0;
            half_bridge_switch_en <= 1'b0;
            startup_current_limit <= 1'b0;
            rail_charge_limit <= 1'b0;
        end else begin
            pfc_st_r <= pfc_st_nxt;
            hb_st_r <= hb_st_nxt;
            system_enable <= !sys_fault;
            startup_current_limit <= supply_short;
            rail_charge_limit <= rail_undervoltage;
            correction_switch_en <= !sys_fault && !line_brownout
                && !pfc_latched_r && pfc_st_nxt == ST_RUN;
            half_bridge_switch_en <= !sys_fault && !line_brownout
                && !correction_output_undervoltage && !resonant_brownout
                && hb_st_nxt == ST_RUN;
        end
    end
endmodule

// ===== verification/pfccfg_asserts.sv
// Concurrent checks on the configuration bank and protection outputs.
`timescale 1ns/10ps
module pfccfg_asserts #(
    parameter TIMER_CYCLES = 10
) (
    // Clock and reset.
    input wire clk,
    input wire rst,
    // Register port.
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_rvalid,
    // Fields and faults.
    input wire [7:0] line_range_threshold,
    input wire [4:0] burst_exit_threshold,
    input wire supply_undervoltage,
    input wire supply_short,
    input wire rail_undervoltage,
    input wire line_brownout,
    input wire correction_output_undervoltage,
    input wire resonant_brownout,
    input wire half_bridge_overcurrent_shutdown,
    input wire latch_shutdown,
    // Actions.
    input wire system_enable,
    input wire correction_switch_en,
    input wire half_bridge_switch_en,
    input wire startup_current_limit,
    input wire rail_charge_limit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_READ_ANSWER: assert property (reg_rd
        |=> reg_rvalid)
        else $error("read request got no answer");
    AST_THR_WRITE: assert property (reg_wr && reg_addr == 8'h05
        |=> line_range_threshold == $past(reg_wdata))
        else $error("threshold write not stored");
    AST_BURST_WRITE: assert property (reg_wr && reg_addr == 8'h0a
        |=> burst_exit_threshold == $past(reg_wdata[4:0]))
        else $error("burst exit write not stored");
    AST_UV_OFF: assert property (supply_undervoltage
        |=> !system_enable && !half_bridge_switch_en)
        else $error("supply undervoltage left system on");
    AST_SHORT_LIMIT: assert property (supply_short
        |=> !system_enable && startup_current_limit)
        else $error("supply short not handled");
    AST_RAIL_LIMIT: assert property (rail_undervoltage
        |=> !system_enable && rail_charge_limit)
        else $error("rail undervoltage not handled");
    AST_BROWNOUT: assert property (line_brownout
        |=> !correction_switch_en && !half_bridge_switch_en)
        else $error("brown-out left switching on");
    AST_HB_SUSPEND: assert property (
        correction_output_undervoltage || resonant_brownout
        |=> !half_bridge_switch_en)
        else $error("half-bridge not suspended");
    AST_OCP_HOLD: assert property ($rose(half_bridge_overcurrent_shutdown)
        |=> !half_bridge_switch_en [*5])
        else $error("half-bridge restarted before timer");
    AST_LATCH_OFF: assert property (latch_shutdown
        |=> !system_enable)
        else $error("latch input left system on");

    cover property (reg_rd ##1 reg_rvalid);
    cover property ($fell(half_bridge_switch_en) ##[1:40] half_bridge_switch_en);
    cover property ($fell(latch_shutdown) ##[1:40] system_enable);
endmodule

bind pfccfg_top pfccfg_asserts #(.TIMER_CYCLES(TIMER_CYCLES)) u_chk (
    .clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rvalid,
    .line_range_threshold, .burst_exit_threshold, .supply_undervoltage,
    .supply_short, .rail_undervoltage, .line_brownout,
    .correction_output_undervoltage, .resonant_brownout,
    .half_bridge_overcurrent_shutdown, .latch_shutdown, .system_enable,
    .correction_switch_en, .half_bridge_switch_en, .startup_current_limit,
    .rail_charge_limit
);

// ===== verification/pfccfg_host.sv
// Host model issuing byte reads and writes on the register port.
`timescale 1ns/10ps
module pfccfg_host (
    // Clock.
    input wire clk,
    // Register requests.
    output reg reg_wr,
    output reg reg_rd,
    output reg [7:0] reg_addr,
    output reg [7:0] reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // Idle address and data are inverted so a stale value is never reused.
    task automatic xfer(input w, input [7:0] a, input [7:0] d, input integer gap);
        begin
            repeat (gap) @(posedge clk);
            @(posedge clk);
            reg_wr <= w;
            reg_rd <= !w;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clk);
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            reg_addr <= ~a;
            reg_wdata <= ~d;
        end
    endtask
endmodule

// ===== verification/tb_pfc_config_and_protection_map.sv
// Self-checking bench for the configuration bank and protection responses.
`timescale 1ns/10ps
module tb_pfc_config_and_protection_map;
    reg clk;
    reg rst;
    reg [10:0] flt;
    wire reg_wr;
    wire reg_rd;
    wire [7:0] reg_addr;
    wire [7:0] reg_wdata;
    wire [7:0] reg_rdata;
    wire [7:0] lthr;
    wire [4:0] burst;
    wire [4:0] outs;
    wire reg_rvalid;
    wire reg_err;
    reg [8:0] expq[$];
    reg [8:0] q9;
    reg [31:0] rng;
    reg [23:0] e;
    reg [7:0] d;
    integer n_fail, total_checks, i, k, n;
    integer cyc = 0;

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    pfccfg_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    pfccfg_top #(.TIMER_CYCLES(10)) DUT (
        .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reg_err(reg_err),
        .supply_undervoltage(flt[0]), .supply_short(flt[1]),
        .rail_undervoltage(flt[2]), .line_brownout(flt[3]),
        .correction_current_limit(flt[4]),
        .correction_output_undervoltage(flt[5]),
        .resonant_brownout(flt[6]),
        .half_bridge_overcurrent_regulation(flt[7]),
        .half_bridge_overcurrent_shutdown(flt[8]),
        .latch_shutdown(flt[9]), .supply_below_reset(flt[10]),
        .system_enable(outs[4]), .correction_switch_en(outs[3]),
        .half_bridge_switch_en(outs[2]), .startup_current_limit(outs[1]),
        .rail_charge_limit(outs[0]),
        .vout_target_high_line(), .vout_target_low_line(),
        .line_range_threshold(lthr), .auto_step_load_level_one(),
        .auto_step_load_level_two(), .burst_exit_threshold(burst),
        .auto_step_load_hysteresis(), .high_line_level_one_low_byte(),
        .high_line_level_two_low_byte(), .high_line_levels_upper_bits(),
        .low_line_level_one_low_byte());

    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction

    // Address, reset byte and writable mask of each writable byte.
    function [23:0] ent(input integer j);
        case (j)
            0: ent = 24'h01_1eff;
            1: ent = 24'h02_0303;
            2: ent = 24'h03_1eff;
            3: ent = 24'h04_0303;
            4: ent = 24'h05_71ff;
            5: ent = 24'h06_fcff;
            6: ent = 24'h07_033f;
            7: ent = 24'h08_32ff;
            8: ent = 24'h09_033f;
            9: ent = 24'h0a_171f;
            10: ent = 24'h0c_f5ff;
            11: ent = 24'h0d_003f;
            12: ent = 24'h0e_1eff;
            13: ent = 24'h0f_1eff;
            14: ent = 24'h11_0f0f;
            15: ent = 24'h12_1eff;
            default: ent = 24'h30_0001;
        endcase
    endfunction

    // Fault bit, expected actions and the action bits that are judged.
    function [23:0] pent(input integer j);
        case (j)
            0: pent = 24'h00_001c;
            1: pent = 24'h01_021e;
            2: pent = 24'h02_011d;
            3: pent = 24'h03_000c;
            4: pent = 24'h05_181c;
            default: pent = 24'h06_0004;
        endcase
    endfunction

    task automatic chk(input [8*12-1:0] nm, input [13:0] ex, input [13:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== ex) begin
                n_fail = n_fail + 1;
                $display("[ERR] %0s expected %h seen %h", nm, ex, got);
            end
        end
    endtask

    task automatic rd(input [7:0] a, input [7:0] ex, input er);
        begin
            expq.push_back({er, ex});
            host.xfer(1'b0, a, 8'h00, 0);
        end
    endtask

    task automatic step(input integer c);
        begin
            repeat (c) @(posedge clk);
            #1;
        end
    endtask

    task automatic setf(input integer b, input v);
        begin
            @(posedge clk);
            flt[b] <= v;
        end
    endtask

    task automatic pulse_reset_level;
        begin
            setf(10, 1'b1);
            step(2);
            setf(10, 1'b0);
            step(2);
        end
    endtask

    task automatic give_verdict;
        begin
            if (n_fail == 0 && total_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    always @(posedge clk) begin
        if (reg_rvalid === 1'b1) begin
            if (expq.size() == 0)
                chk("extra_answer", 14'h0000, 14'h0001);
            else begin
                q9 = expq.pop_front();
                chk("rdata", q9[7:0], reg_rdata);
                chk("err", q9[8], reg_err);
            end
        end
    end

    // A hang ends the run as a failure.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_fail = n_fail + 1;
            give_verdict;
        end
    end

    initial begin
        rst = 1'b1;
        flt = 11'h000;
        rng = 32'h8cfa_58d2;
        n_fail = 0;
        total_checks = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 17; i = i + 1) begin
            e = ent(i);
            rd(e[23:16], e[15:8], 1'b0);
        end
        rd(8'h0b, 8'h00, 1'b1);
        rd(8'h13, 8'h00, 1'b1);
        step(3);
        chk("line_thr", 8'h71, lthr);
        chk("burst", 5'h17, burst);
        // First pass writes all ones, then random bytes with random gaps.
        for (k = 0; k < 4; k = k + 1) begin
            for (i = 0; i < 17; i = i + 1) begin
                e = ent(i);
                rng = xs(rng);
                d = (k == 0) ? 8'hff : rng[7:0];
                host.xfer(1'b1, e[23:16], d, rng[9:8]);
                host.xfer(1'b1, 8'h0b, ~d, 0);
                rd(e[23:16], d & e[7:0], 1'b0);
            end
        end
        step(3);
        chk("pending", 14'h0000, expq.size());
        host.xfer(1'b1, 8'h30, 8'h00, 0);
        step(30);
        for (i = 0; i < 6; i = i + 1) begin
            e = pent(i);
            setf(e[19:16], 1'b1);
            step(2);
            chk("fault_act", e[12:8], outs & e[4:0]);
            setf(e[19:16], 1'b0);
            step(2);
            chk("recovered", 5'b11100, outs);
        end
        // Timed restarts: regulation, shutdown, then current limit.
        for (i = 0; i < 3; i = i + 1) begin
            k = (i == 2) ? 4 : 7 + i;
            n = (i == 2) ? 3 : 2;
            setf(k, 1'b1);
            step(3 - i);
            setf(k, 1'b0);
            step(3);
            if (i < 2)
                chk("held_off", 14'h0000, outs[n]);
            k = 0;
            while (outs[n] !== 1'b1 && k < 40) begin
                step(1);
                k = k + 1;
            end
            chk("restarted", 14'h0001, outs[n]);
        end
        host.xfer(1'b1, 8'h30, 8'h01, 0);
        setf(4, 1'b1);
        step(2);
        setf(4, 1'b0);
        step(30);
        chk("corr_latched", 14'h0000, outs[3]);
        pulse_reset_level;
        chk("corr_release", 14'h0001, outs[3]);
        setf(9, 1'b1);
        step(2);
        setf(9, 1'b0);
        step(30);
        chk("sys_latched", 14'h0000, outs[4]);
        pulse_reset_level;
        chk("sys_release", 14'h0001, outs[4]);
        give_verdict;
    end
endmodule
